// *** verilog/gsc_pkg.sv ***
// shared constants, types and check-byte function for the gas sensor command link
package gsc_pkg;
  // ************************************************************
  // command codes
  // ************************************************************
  localparam logic [15:0] CMD_START = 16'h21B1; // begin periodic measurement
  localparam logic [15:0] CMD_READ = 16'hEC05; // read result set
  localparam logic [15:0] CMD_STOP = 16'h3F86; // back to idle
  localparam logic [15:0] CMD_SET_TOFF = 16'h241D; // temperature offset, one parameter word
  localparam logic [15:0] CMD_SET_PRESS = 16'hE000; // ambient pressure, one parameter word
  // ************************************************************
  // frame layout
  // ************************************************************
  localparam logic [2:0] LEN_BARE = 3'h2; // command word only
  localparam logic [2:0] LEN_PARAM = 3'h5; // command word, parameter word, check byte
  localparam logic [2:0] LEN_OVER = 3'h6; // too many bytes in one write
  localparam logic [3:0] LEN_RESULT = 4'h9; // three words with check bytes
  // ************************************************************
  // check byte
  // ************************************************************
  localparam logic [7:0] CRC_POLY = 8'h31; // polynomial, plain default
  localparam logic [7:0] CRC_INIT = 8'hFF; // start value
  // ************************************************************
  // reset values
  // ************************************************************
  // 4 degrees scaled by 65536/175, rounded to nearest
  localparam logic [15:0] TOFF_RESET = 16'((4 * 65536 + 87) / 175);
  localparam logic [15:0] PRESS_RESET = 16'h0000; // no pressure given yet
  // ************************************************************
  // timing
  // ************************************************************
  localparam int unsigned CLK_HZ = 40_000_000; // 25 ns period
  localparam int unsigned UPDATE_S = 5; // result update interval, seconds
  localparam int unsigned STOP_MS = 500; // quiet time after stop, ms
  localparam int unsigned EXEC_MS = 1; // command execution time, ms
  localparam int unsigned UPDATE_CYC = UPDATE_S * CLK_HZ;
  localparam int unsigned STOP_CYC = STOP_MS * (CLK_HZ / 1000);
  localparam int unsigned EXEC_CYC = EXEC_MS * (CLK_HZ / 1000);
  // device modes
  typedef enum logic [1:0]
  {
    MODE_IDLE = 2'b00,
    MODE_MEAS = 2'b01,
    MODE_QUIET = 2'b10
  } gsc_mode_type;
  // does a command carry a parameter word
  function automatic logic has_param(input logic [15:0] c);
    has_param = (c == CMD_SET_TOFF) || (c == CMD_SET_PRESS);
  endfunction
  // check byte over one 16-bit word, msb first
  function automatic logic [7:0] crc8(input logic [15:0] w);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = 15; i >= 0; i--)
    begin
      c = (c[7] ^ w[i]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    crc8 = c;
  endfunction
endpackage

// *** verilog/gsc_link_if.sv ***
// byte-level command link between host and sensor command core
`timescale 1ns/1ps
interface gsc_link_if;
  logic wr_valid; // host offers a write byte
  logic [7:0] wr_data; // write byte
  logic wr_ready; // device takes the byte
  logic wr_end; // host ends the write frame, one cycle
  logic rd_start; // host opens a read phase, one cycle
  logic rd_valid; // device offers a read byte
  logic [7:0] rd_data; // read byte
  logic rd_ready; // host takes the read byte
  logic rd_nack; // device refuses the read, one cycle
  logic rd_end; // host ends the read phase early or at its end, one cycle
  modport dev (input wr_valid, wr_data, wr_end, rd_start, rd_ready, rd_end,
               output wr_ready, rd_valid, rd_data, rd_nack);
  modport host (output wr_valid, wr_data, wr_end, rd_start, rd_ready, rd_end,
                input wr_ready, rd_valid, rd_data, rd_nack);
endinterface

// *** verilog/gsc_dev.sv ***
// sensor-side command interpreter for the gas sensor link
//
// Summary of operation
// - start command begins five second measurement
// - host sends only allowed commands while measuring
// - read returns gas, temperature, humidity with checks
// - opening a read phase empties the result buffer
// - read with empty buffer is answered NACK
// - early NACK and STOP drops remaining bytes
// - host waits 1 ms before read phase
// - temperature word scaled -45 plus 175
// - humidity word scaled 100 percent
// - stop command returns device to idle
// - commands ignored for 500 ms after stop
// - offset command accepted only in idle; pressure also while measuring
// - host persists settings if they must survive
// - offset command stores word, done within 1 ms
// - temperature offset resets to 4 degrees
// - offset adjusts temperature and humidity, not gas
// - pressure command accepted while measuring too
`timescale 1ns/1ps
module gsc_dev #(
  parameter int unsigned UPDATE_CYC = gsc_pkg::UPDATE_CYC,
  parameter int unsigned STOP_CYC = gsc_pkg::STOP_CYC
) (
  // clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // link to host
  gsc_link_if.dev LINK,
  // raw sensing front end, same clock
  input wire logic [15:0] GAS_IN,
  input wire logic [15:0] TEMP_IN,
  input wire logic [15:0] HUM_IN,
  // status to the sensor core
  output logic MEASURING,
  output logic SAMPLE,
  output logic CMD_ERR,
  output logic [15:0] TOFFSET,
  output logic [15:0] PRESSURE
);
  // ************************************************************
  // state
  // ************************************************************
  gsc_pkg::gsc_mode_type mode_r; // idle, measuring or quiet
  logic [31:0] tmr_r; // update or quiet countdown
  logic [2:0] nb_r; // bytes of current write frame
  logic [39:0] sh_r; // write frame bytes, last byte low
  logic [47:0] res_r; // latest result set gas, temp, hum
  logic avail_r; // result set not yet read
  logic armed_r; // read command seen, read phase may follow
  logic busy_r; // serializer active
  logic [3:0] left_r; // bytes still to push
  logic [71:0] ser_r; // outgoing read bytes, first byte high
  logic [7:0] mem_r [2]; // two-entry read buffer
  logic wp_r; // buffer write pointer
  logic rp_r; // buffer read pointer
  logic [1:0] cnt_r; // buffer fill level
  logic wr_ready_r; // write byte accept
  logic rd_valid_r; // read byte present
  logic rd_nack_r; // refusal pulse
  logic [7:0] rd_data_r; // read byte, registered head of the buffer
  // ************************************************************
  // frame decode
  // ************************************************************
  wire take_w = LINK.wr_valid && wr_ready_r; // byte accepted this cycle
  wire [15:0] cmd_w = (nb_r == gsc_pkg::LEN_PARAM) ? sh_r[39:24] : sh_r[15:0];
  wire [15:0] par_w = sh_r[23:8]; // parameter word
  wire need_w = gsc_pkg::has_param(cmd_w);
  // length must match the command and the parameter check byte must hold
  wire len_ok_w = nb_r == (need_w ? gsc_pkg::LEN_PARAM : gsc_pkg::LEN_BARE);
  wire crc_ok_w = !need_w || (gsc_pkg::crc8(par_w) == sh_r[7:0]);
  wire is_idle_w = mode_r == gsc_pkg::MODE_IDLE;
  wire is_meas_w = mode_r == gsc_pkg::MODE_MEAS;
  // in idle any known command; while measuring only read, stop and pressure
  wire legal_w = (cmd_w == gsc_pkg::CMD_READ) || (cmd_w == gsc_pkg::CMD_STOP) ||
                 (cmd_w == gsc_pkg::CMD_SET_PRESS) ||
                 (is_idle_w && ((cmd_w == gsc_pkg::CMD_START) ||
                 (cmd_w == gsc_pkg::CMD_SET_TOFF)));
  wire open_w = LINK.wr_end && (mode_r != gsc_pkg::MODE_QUIET); // quiet mode drops frames
  wire act_w = open_w && len_ok_w && crc_ok_w && legal_w;
  wire bad_w = open_w && !(len_ok_w && crc_ok_w && legal_w);
  wire do_start_w = act_w && (cmd_w == gsc_pkg::CMD_START);
  wire do_stop_w = act_w && (cmd_w == gsc_pkg::CMD_STOP);
  wire do_read_w = act_w && (cmd_w == gsc_pkg::CMD_READ);
  wire do_toff_w = act_w && (cmd_w == gsc_pkg::CMD_SET_TOFF);
  wire do_press_w = act_w && (cmd_w == gsc_pkg::CMD_SET_PRESS);
  // ************************************************************
  // measurement timing and compensation
  // ************************************************************
  wire tick_w = is_meas_w && (tmr_r == 32'h0000_0000); // new result set due
  wire [15:0] temp_w = (TEMP_IN > TOFFSET) ? (TEMP_IN - TOFFSET) : 16'h0000;
  // offset and temperature scales match, so the word is subtracted directly
  wire [16:0] hum_sum_w = {1'b0, HUM_IN} + {2'b00, TOFFSET[15:1]};
  // a cooler true reading means higher relative humidity; saturate at full scale
  wire [15:0] hum_w = hum_sum_w[16] ? 16'hFFFF : hum_sum_w[15:0];
  // ************************************************************
  // read phase decode
  // ************************************************************
  wire give_w = LINK.rd_start && armed_r && avail_r && !busy_r;
  wire refuse_w = LINK.rd_start && !give_w;
  wire push_w = busy_r && (cnt_r != 2'b10) && !LINK.rd_end; // stalls while buffer full
  wire pop_w = rd_valid_r && LINK.rd_ready;
  wire [1:0] cnt_nxt = LINK.rd_end ? 2'b00 : 2'(cnt_r + {1'b0, push_w} - {1'b0, pop_w});
  // ************************************************************
  // mode and timer
  // ************************************************************
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      mode_r <= gsc_pkg::MODE_IDLE;
      tmr_r <= 32'h0000_0000;
    end
    else if (do_start_w)
    begin
      mode_r <= gsc_pkg::MODE_MEAS;
      tmr_r <= UPDATE_CYC - 1;
    end
    else if (do_stop_w)
    begin
      mode_r <= gsc_pkg::MODE_QUIET;
      tmr_r <= STOP_CYC - 1;
    end
    else if (tmr_r != 32'h0000_0000)
    begin
      tmr_r <= tmr_r - 1;
    end
    else if (is_meas_w)
    begin
      tmr_r <= UPDATE_CYC - 1;
    end
    else
    begin
      mode_r <= gsc_pkg::MODE_IDLE; // quiet time over
    end
  end
  // ************************************************************
  // write frame capture
  // ************************************************************
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      nb_r <= 3'h0;
      sh_r <= 40'h00_0000_0000;
      wr_ready_r <= 1'b0;
    end
    else
    begin
      wr_ready_r <= 1'b1; // bytes always taken; quiet mode discards them at frame end
      if (LINK.wr_end)
      begin
        nb_r <= 3'h0;
      end
      else if (take_w)
      begin
        sh_r <= {sh_r[31:0], LINK.wr_data};
        nb_r <= (nb_r == gsc_pkg::LEN_OVER) ? nb_r : nb_r + 3'h1;
      end
    end
  end
  // ************************************************************
  // settings, result buffer and status
  // ************************************************************
  // settings take the parameter word of an accepted frame at once
  wire [15:0] toff_nxt = do_toff_w ? par_w : TOFFSET;
  wire [15:0] press_nxt = do_press_w ? par_w : PRESSURE;
  wire [47:0] res_nxt = tick_w ? {GAS_IN, temp_w, hum_w} : res_r; // gas passes untouched
  // a fresh set wins over the emptying by a read in the same cycle
  wire avail_nxt = tick_w || (avail_r && !(give_w || do_stop_w));
  // a read frame arms; a read phase or any other frame disarms
  wire armed_nxt = do_read_w || (armed_r && !(LINK.rd_start || open_w));
  // status outputs are registered copies so they never glitch
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      TOFFSET <= gsc_pkg::TOFF_RESET;
      PRESSURE <= gsc_pkg::PRESS_RESET;
      res_r <= 48'h0000_0000_0000;
      avail_r <= 1'b0;
      armed_r <= 1'b0;
      MEASURING <= 1'b0;
      SAMPLE <= 1'b0;
      CMD_ERR <= 1'b0;
    end
    else
    begin
      TOFFSET <= toff_nxt;
      PRESSURE <= press_nxt;
      res_r <= res_nxt;
      avail_r <= avail_nxt;
      armed_r <= armed_nxt;
      MEASURING <= is_meas_w;
      SAMPLE <= tick_w;
      CMD_ERR <= bad_w; // refused code, bad length or bad check byte
    end
  end
  // ************************************************************
  // serializer
  // ************************************************************
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      busy_r <= 1'b0;
      left_r <= 4'h0;
      ser_r <= 72'h00_0000_0000_0000_0000;
    end
    else if (LINK.rd_end)
    begin
      busy_r <= 1'b0; // host gave up, rest dropped
    end
    else if (give_w)
    begin
      busy_r <= 1'b1;
      left_r <= gsc_pkg::LEN_RESULT;
      ser_r <= {res_r[47:32], gsc_pkg::crc8(res_r[47:32]), res_r[31:16],
                gsc_pkg::crc8(res_r[31:16]), res_r[15:0], gsc_pkg::crc8(res_r[15:0])};
    end
    else if (push_w)
    begin
      ser_r <= {ser_r[63:0], 8'h00};
      left_r <= left_r - 4'h1;
      busy_r <= left_r != 4'h1;
    end
  end
  // ************************************************************
  // two-entry read buffer
  // ************************************************************
  // head after this edge; a push into an empty or draining buffer becomes the head at once
  wire rp_nxt = LINK.rd_end ? 1'b0 : rp_r ^ pop_w;
  wire [7:0] rd_data_nxt = (push_w && (wp_r == rp_nxt)) ? ser_r[71:64] : mem_r[rp_nxt];
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      mem_r[0] <= 8'h00;
      mem_r[1] <= 8'h00;
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= 2'b00;
      rd_valid_r <= 1'b0;
      rd_nack_r <= 1'b0;
      rd_data_r <= 8'h00;
    end
    else
    begin
      if (push_w)
      begin
        mem_r[wp_r] <= ser_r[71:64];
      end
      // flush resets both pointers so the next read starts clean
      wp_r <= LINK.rd_end ? 1'b0 : wp_r ^ push_w;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
      rd_valid_r <= cnt_nxt != 2'b00;
      rd_nack_r <= refuse_w;
      rd_data_r <= rd_data_nxt; // read byte leaves a flip-flop
    end
  end
  assign LINK.wr_ready = wr_ready_r;
  assign LINK.rd_valid = rd_valid_r;
  assign LINK.rd_data = rd_data_r;
  assign LINK.rd_nack = rd_nack_r;
endmodule

// *** verilog/gsc_host.sv ***
// host-side command sequencer for the gas sensor link
`timescale 1ns/1ps
module gsc_host #(
  parameter int unsigned EXEC_CYC = gsc_pkg::EXEC_CYC,
  parameter int unsigned STOP_CYC = gsc_pkg::STOP_CYC
) (
  // clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // link to sensor
  gsc_link_if.host LINK,
  // command request
  input wire logic CMD_VALID,
  input wire logic [15:0] CMD_CODE,
  input wire logic [15:0] CMD_PARAM,
  input wire logic [3:0] RD_LEN,
  input wire logic RX_HOLD,
  output logic CMD_READY,
  output logic CMD_REFUSED,
  // results
  output logic RES_VALID,
  output logic RES_NACK,
  output logic RES_CRC_ERR,
  output logic [15:0] RES_GAS,
  output logic [15:0] RES_TEMP,
  output logic [15:0] RES_HUM,
  output logic HOST_MEAS
);
  // ************************************************************
  // state
  // ************************************************************
  typedef enum logic [2:0]
  {
    HS_IDLE = 3'b000,
    HS_SEND = 3'b001,
    HS_EXEC = 3'b010,
    HS_READ = 3'b011,
    HS_DONE = 3'b100
  } gsc_hstate_type;
  gsc_hstate_type st_r; // sequencer state
  logic [39:0] tx_r; // bytes to send, first byte high
  logic [2:0] nleft_r; // bytes still to send
  logic [15:0] code_r; // command in flight
  logic [3:0] len_r; // read bytes wanted
  logic [3:0] got_r; // read bytes received
  logic [71:0] rx_r; // received bytes, first byte high
  logic [31:0] tmr_r; // execution or quiet wait
  logic wr_valid_r, wr_end_r, rd_start_r, rd_ready_r, rd_end_r;
  // ************************************************************
  // decode
  // ************************************************************
  // while measuring only read, stop and pressure go out
  wire ok_meas_w = (CMD_CODE == gsc_pkg::CMD_READ) || (CMD_CODE == gsc_pkg::CMD_STOP) ||
                   (CMD_CODE == gsc_pkg::CMD_SET_PRESS);
  wire accept_w = CMD_VALID && CMD_READY && (!HOST_MEAS || ok_meas_w);
  wire refuse_w = CMD_VALID && CMD_READY && HOST_MEAS && !ok_meas_w;
  wire send_w = wr_valid_r && LINK.wr_ready;
  wire byte_w = rd_ready_r && LINK.rd_valid;
  wire last_w = byte_w && ((got_r + 4'h1) == len_r);
  wire is_read_w = code_r == gsc_pkg::CMD_READ;
  wire is_stop_w = code_r == gsc_pkg::CMD_STOP;
  // ************************************************************
  // sequencer
  // ************************************************************
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      st_r <= HS_IDLE;
      tx_r <= 40'h00_0000_0000;
      nleft_r <= 3'h0;
      code_r <= 16'h0000;
      len_r <= 4'h0;
      got_r <= 4'h0;
      rx_r <= 72'h00_0000_0000_0000_0000;
      tmr_r <= 32'h0000_0000;
      {wr_valid_r, wr_end_r, rd_start_r, rd_ready_r, rd_end_r} <= 5'h00;
      {CMD_READY, CMD_REFUSED, RES_VALID, RES_NACK, RES_CRC_ERR, HOST_MEAS} <= 6'h00;
      {RES_GAS, RES_TEMP, RES_HUM} <= 48'h0000_0000_0000;
    end
    else
    begin
      // one-cycle pulses default low
      {wr_end_r, rd_start_r, rd_end_r, CMD_REFUSED, RES_VALID, RES_NACK} <= 6'h00;
      case (st_r)
        HS_IDLE:
        begin
          CMD_READY <= 1'b1;
          CMD_REFUSED <= refuse_w;
          if (accept_w)
          begin
            CMD_READY <= 1'b0;
            code_r <= CMD_CODE;
            len_r <= (RD_LEN == 4'h0 || RD_LEN > gsc_pkg::LEN_RESULT) ? gsc_pkg::LEN_RESULT : RD_LEN;
            tx_r <= {CMD_CODE, CMD_PARAM, gsc_pkg::crc8(CMD_PARAM)};
            nleft_r <= gsc_pkg::has_param(CMD_CODE) ? gsc_pkg::LEN_PARAM : gsc_pkg::LEN_BARE;
            wr_valid_r <= 1'b1;
            st_r <= HS_SEND;
          end
        end
        HS_SEND:
        begin
          if (send_w)
          begin
            tx_r <= {tx_r[31:0], 8'h00};
            nleft_r <= nleft_r - 3'h1;
            if (nleft_r == 3'h1)
            begin
              wr_valid_r <= 1'b0;
              wr_end_r <= 1'b1;
              // a stop also holds off everything for the quiet time
              tmr_r <= is_stop_w ? STOP_CYC - 1 : EXEC_CYC - 1;
              HOST_MEAS <= (code_r == gsc_pkg::CMD_START) || (HOST_MEAS && !is_stop_w);
              st_r <= HS_EXEC;
            end
          end
        end
        HS_EXEC:
        begin
          if (tmr_r != 32'h0000_0000)
          begin
            tmr_r <= tmr_r - 1;
          end
          else if (is_read_w)
          begin
            rd_start_r <= 1'b1;
            rd_ready_r <= 1'b1;
            got_r <= 4'h0;
            rx_r <= 72'h00_0000_0000_0000_0000;
            st_r <= HS_READ;
          end
          else
          begin
            st_r <= HS_IDLE;
          end
        end
        HS_READ:
        begin
          rd_ready_r <= !RX_HOLD && !last_w; // stalls let the device buffer fill
          if (LINK.rd_nack)
          begin
            RES_NACK <= 1'b1; // nothing buffered
            rd_ready_r <= 1'b0;
            st_r <= HS_IDLE;
          end
          else if (byte_w)
          begin
            rx_r[7'(71 - 8 * got_r) -: 8] <= LINK.rd_data;
            got_r <= got_r + 4'h1;
            if (last_w)
            begin
              rd_end_r <= 1'b1; // closes the read, early or full
              st_r <= HS_DONE;
            end
          end
        end
        HS_DONE:
        begin
          RES_VALID <= 1'b1;
          RES_GAS <= rx_r[71:56];
          RES_TEMP <= rx_r[47:32];
          RES_HUM <= rx_r[23:8];
          // checks only judged on a full read
          RES_CRC_ERR <= (len_r == gsc_pkg::LEN_RESULT) && ((gsc_pkg::crc8(rx_r[71:56]) != rx_r[55:48]) ||
                         (gsc_pkg::crc8(rx_r[47:32]) != rx_r[31:24]) ||
                         (gsc_pkg::crc8(rx_r[23:8]) != rx_r[7:0]));
          st_r <= HS_IDLE;
        end
        default:
        begin
          st_r <= HS_IDLE;
        end
      endcase
    end
  end
  assign LINK.wr_valid = wr_valid_r;
  assign LINK.wr_data = tx_r[39:32];
  assign LINK.wr_end = wr_end_r;
  assign LINK.rd_start = rd_start_r;
  assign LINK.rd_ready = rd_ready_r;
  assign LINK.rd_end = rd_end_r;
endmodule

// *** dv/gsc_link_asserts.sv ***
// protocol checker on the read and write sides of the command link
`timescale 1ns/1ps
module gsc_link_asserts (
  // clock, reset and link signals
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic wr_ready,
  input wire logic rd_start,
  input wire logic rd_valid,
  input wire logic [7:0] rd_data,
  input wire logic rd_ready,
  input wire logic rd_nack,
  input wire logic rd_end
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  property p_nack_one; rd_nack |=> !rd_nack; endproperty
  a_nack_one: assert property (p_nack_one) else $error("nack too long");
  property p_nack_why; rd_nack |-> $past(rd_start); endproperty
  a_nack_why: assert property (p_nack_why) else $error("nack unasked");
  property p_answer; rd_start |=> rd_nack or ##1 rd_valid; endproperty
  a_answer: assert property (p_answer) else $error("read unanswered");
  property p_excl; rd_nack |-> !rd_valid; endproperty
  a_excl: assert property (p_excl) else $error("nack with data");
  property p_hold; rd_valid && !rd_ready && !rd_end |=> rd_valid && $stable(rd_data); endproperty
  a_hold: assert property (p_hold) else $error("byte lost in stall");
  property p_flush; rd_end |-> ##2 !rd_valid; endproperty
  a_flush: assert property (p_flush) else $error("bytes kept");
  property p_fresh; rd_start |-> !rd_valid; endproperty
  a_fresh: assert property (p_fresh) else $error("stale bytes");
  property p_wr_rdy; !$past(SYS_RST) |-> wr_ready; endproperty
  a_wr_rdy: assert property (p_wr_rdy) else $error("write not ready");
endmodule

// *** dv/gas_sensor_i2c_command_core_tb.sv ***
// bench joining host and sensor ends of the command link
`timescale 1ns/1ps
`define CHK(n,e,a) begin checked++; if ((a)!==(e)) begin n_errors++; $display("[ERR] %s exp %h got %h",n,e,a); end end
module gas_sensor_i2c_command_core_tb;
  // stimulus
  logic CLK = 1'b0;
  logic SYS_RST = 1'b1;
  logic c_vld = 1'b0;
  logic rx_hold = 1'b0;
  logic [3:0] c_len = 4'h9;
  logic [15:0] c_code = 16'h0000, c_par = 16'h0000, toff, gas = 16'h0000, temp = 16'h0000, hum = 16'h0000;
  // outputs and gathered answers
  logic meas, smp, err, c_rdy, c_ref, r_vld, r_nack, r_crc, h_meas, got_v, got_n, got_r, got_e;
  logic [15:0] toff_o, press, r_gas, r_temp, r_hum;
  logic [7:0] rxq[$];
  int n_errors = 0;
  int checked = 0;
  gsc_link_if i_gsc_link_if ();
  gsc_dev #(.UPDATE_CYC(200), .STOP_CYC(50)) i_gsc_dev (.CLK(CLK), .SYS_RST(SYS_RST), .LINK(i_gsc_link_if),
    .GAS_IN(gas), .TEMP_IN(temp), .HUM_IN(hum), .MEASURING(meas), .SAMPLE(smp), .CMD_ERR(err),
    .TOFFSET(toff_o), .PRESSURE(press));
  gsc_host #(.EXEC_CYC(10), .STOP_CYC(50)) i_gsc_host (.CLK(CLK), .SYS_RST(SYS_RST), .LINK(i_gsc_link_if),
    .CMD_VALID(c_vld), .CMD_CODE(c_code), .CMD_PARAM(c_par), .RD_LEN(c_len), .RX_HOLD(rx_hold),
    .CMD_READY(c_rdy), .CMD_REFUSED(c_ref), .RES_VALID(r_vld), .RES_NACK(r_nack), .RES_CRC_ERR(r_crc),
    .RES_GAS(r_gas), .RES_TEMP(r_temp), .RES_HUM(r_hum), .HOST_MEAS(h_meas));
  gsc_link_asserts i_gsc_link_asserts (.CLK(CLK), .SYS_RST(SYS_RST), .wr_ready(i_gsc_link_if.wr_ready),
    .rd_start(i_gsc_link_if.rd_start), .rd_valid(i_gsc_link_if.rd_valid), .rd_data(i_gsc_link_if.rd_data),
    .rd_ready(i_gsc_link_if.rd_ready), .rd_nack(i_gsc_link_if.rd_nack), .rd_end(i_gsc_link_if.rd_end));
  // clock, random receiver stalls so the buffer fills, log of read bytes
  always #12.5 CLK = ~CLK;
  always @(negedge CLK) rx_hold <= 1'($urandom);
  always @(posedge CLK) if (i_gsc_link_if.rd_valid && i_gsc_link_if.rd_ready) rxq.push_back(i_gsc_link_if.rd_data);
  // expected words: offset lowers temperature and raises humidity, both saturate
  function automatic logic [15:0] f_temp(input logic [15:0] t);
    return (t > toff) ? t - toff : 16'h0000;
  endfunction
  function automatic logic [15:0] f_hum(input logic [15:0] h);
    logic [16:0] s;
    s = {1'b0, h} + {2'h0, toff[15:1]};
    return s[16] ? 16'hFFFF : s[15:0];
  endfunction
  task automatic final_report();
    if (n_errors == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // one cycle of a wait; a wait that runs too long ends the run
  task automatic step(inout int i);
    @(negedge CLK);
    i++;
    if (i > 5000)
    begin
      `CHK("timeout", 1'b0, 1'b1)
      final_report();
    end
  endtask
  // hand one command to the host, then gather its answer pulses
  task automatic send(input logic [15:0] c, input logic [15:0] p, input logic [3:0] n);
    int i;
    i = 0;
    {got_v, got_n, got_r, got_e} = 4'h0;
    while (!c_rdy)
      step(i);
    {c_code, c_par, c_len, c_vld} = {c, p, n, 1'b1};
    while (i < 5 || !c_rdy || (c == gsc_pkg::CMD_READ && !(got_v | got_n)))
    begin
      step(i);
      c_vld = 1'b0;
      {got_v, got_n, got_r, got_e} = {got_v | r_vld, got_n | r_nack, got_r | c_ref, got_e | err};
    end
  endtask
  // present a set, let a tick take it, read it back, then read again too soon
  task automatic rd_chk(input logic [15:0] g, input logic [15:0] t, input logic [15:0] h, input logic [3:0] n);
    int i;
    i = 0;
    {gas, temp, hum} = {g, t, h};
    repeat (2)
      step(i);
    while (!smp)
      step(i);
    rxq.delete();
    send(gsc_pkg::CMD_READ, 16'h0000, n);
    `CHK("r_vld", 1'b1, got_v)
    `CHK("r_gas", g, r_gas)
    `CHK("wire_n", 32'(n), rxq.size())
    `CHK("wire_gas", g, {rxq[0], rxq[1]})
    if (n == 4'h9)
    begin
      `CHK("r_temp", f_temp(t), r_temp)
      `CHK("r_hum", f_hum(h), r_hum)
      `CHK("r_crc", 1'b0, r_crc)
    end
    send(gsc_pkg::CMD_READ, 16'h0000, 4'h9);
    `CHK("empty", 1'b1, got_n)
  endtask
  initial
  begin
    void'($urandom(46875));
    toff = 16'($urandom);
    repeat (16) @(negedge CLK);
    SYS_RST = 1'b0;
    `CHK("toff_o", 16'h05DA, toff_o)
    send(gsc_pkg::CMD_SET_TOFF, toff, 4'h9);
    `CHK("toff_o", toff, toff_o)
    send(gsc_pkg::CMD_START, 16'h0000, 4'h9);
    `CHK("meas", 2'b11, {meas, h_meas})
    `CHK("start_err", 1'b0, got_e)
    send(gsc_pkg::CMD_READ, 16'h0000, 4'h9);
    `CHK("nack", 1'b1, got_n)
    send(gsc_pkg::CMD_SET_TOFF, ~toff, 4'h9);
    `CHK("refused", 1'b1, got_r)
    `CHK("toff_o", toff, toff_o)
    send(gsc_pkg::CMD_SET_PRESS, 16'h03DB, 4'h9);
    `CHK("press", 16'h03DB, press)
    rd_chk(16'h01F4, 16'h0000, 16'hFFFF, 4'h9);
    repeat (4)
      rd_chk(16'($urandom), 16'($urandom), 16'($urandom), 4'h9);
    rd_chk(16'($urandom), 16'($urandom), 16'($urandom), 4'h2);
    send(gsc_pkg::CMD_STOP, 16'h0000, 4'h9);
    `CHK("meas", 1'b0, meas)
    send(gsc_pkg::CMD_SET_TOFF, 16'h0000, 4'h9);
    `CHK("toff_o", 16'h0000, toff_o)
    // a code that no command owns must be refused by the sensor end
    send(16'h1234, 16'h0000, 4'h9);
    `CHK("unknown_err", 1'b1, got_e)
    final_report();
  end
endmodule
